// ===== hdl/block_tx_engine.sv
`timescale 1ns/10ps
module block_tx_engine
  import can_global_pkg::*;
#(
  parameter int CLEAR_CYCLES = ENGINE_CLEAR_CYCLES,
  parameter int BUFFERS      = BLOCK_TX_BUFFERS
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic          clear_req,
  input  wire logic          tx_done,
  output block_tx_status_type status
);

  typedef enum logic [1:0] {ENGINE_IDLE, ENGINE_RUN, ENGINE_CLEAR} engine_state_type;

  engine_state_type              state;
  logic [3:0]                    clear_count;
  logic [BLOCK_TX_PTR_WIDTH-1:0] buffer;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ENGINE_IDLE;
    end else begin
      case (state)
        ENGINE_IDLE: begin
          if (clear_req) begin
            state <= ENGINE_CLEAR;
          end else if (start) begin
            state <= ENGINE_RUN;
          end
        end
        ENGINE_RUN: begin
          if (clear_req || stop) begin
            state <= clear_req ? ENGINE_CLEAR : ENGINE_IDLE;
          end
        end
        ENGINE_CLEAR: begin
          if (clear_count == 4'(CLEAR_CYCLES - 1)) begin
            state <= ENGINE_IDLE;  // [RULE12]
          end
        end
        default: state <= ENGINE_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_count <= '0;
    end else if (state == ENGINE_CLEAR) begin
      clear_count <= clear_count + 1'b1;
    end else begin
      clear_count <= '0;
    end
  end

  // clearing rewinds the walk so the next start begins at buffer 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer <= '0;
    end else if (state == ENGINE_CLEAR) begin
      buffer <= '0;  // [RULE13]
    end else if (state == ENGINE_RUN && tx_done) begin
      buffer <= (buffer == BLOCK_TX_PTR_WIDTH'(BUFFERS - 1)) ? '0 : buffer + 1'b1;
    end
  end

  assign status.running  = (state == ENGINE_RUN);    // [RULE11]
  assign status.clearing = (state == ENGINE_CLEAR);  // [RULE12]
  assign status.buffer   = buffer;

endmodule // block_tx_engine

// ===== hdl/can_global_control.sv
// What the document requires of this block and of its software
// [RULE1] buffer access flag is read-only to software
// [RULE2] access flag follows sleep/stop and global operation
// [RULE3] blocked flag denies buffer and history access
// [RULE4] set/clear pattern drives global operation bit
// [RULE5] global operation enables the whole module
// [RULE6] clear accepted in init or after shutdown-enable
// [RULE7] any other access drops shutdown-enable flag
// [RULE8] bit nine write sets shutdown-enable flag
// [RULE9] software sets global operation, shutdown separately
// [RULE10] module clock is input over selector plus one
// [RULE11] run flag started and stopped by pattern
// [RULE12] engine clear status self-clears when done
// [RULE13] after clear, transmission restarts at buffer zero
// [RULE14] software clears engine only while stopped
// [RULE15] software never starts transmission in init mode
// [RULE16] software restores control default before init
// [RULE17] set/clear pairs: lone set sets, lone clear clears
// [RULE18] software uses paired encoding, never read-modify-write
`timescale 1ns/10ps
module can_global_control
  import can_global_pkg::*;
#(
  parameter int CLEAR_CYCLES = ENGINE_CLEAR_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [DATA_WIDTH-1:0] pwdata,
  output logic      [DATA_WIDTH-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  init_mode,
  input  wire logic                  sleep_stop_entry,
  input  wire logic                  sleep_stop_release,
  input  wire buffer_req_type        buffer_req,
  output logic                       buffer_grant,
  input  wire logic                  block_tx_done,
  output block_tx_status_type        block_tx_status,
  output logic                       module_enable,
  output logic                       module_clock_tick
);

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic                    setup_phase;
  logic                    access_done;
  logic                    hit_global;
  logic                    hit_block_tx;
  logic                    hit_clock_sel;
  logic                    hit_any;
  logic                    gc_write;
  logic                    bt_write;
  logic                    cs_write;
  logic [REG_WIDTH-1:0]    wdata;

  logic                    global_operation;
  logic                    forced_shutdown_enable;
  logic                    buffer_access_enabled;
  logic [7:0]              module_clock_select;
  logic                    next_global_operation;
  logic                    global_op_rise;
  logic                    global_op_fall;
  logic                    other_access;

  assign setup_phase   = psel && !penable;
  assign access_done   = psel && penable && pready;
  assign hit_global    = (paddr == GLOBAL_CONTROL_ADDR);
  assign hit_block_tx  = (paddr == BLOCK_TX_ADDR);
  assign hit_clock_sel = (paddr == CLOCK_SELECT_ADDR);
  assign hit_any       = hit_global || hit_block_tx || hit_clock_sel;
  assign wdata         = pwdata[REG_WIDTH-1:0];
  assign gc_write      = access_done && pwrite && hit_global;
  assign bt_write      = access_done && pwrite && hit_block_tx;
  assign cs_write      = access_done && pwrite && hit_clock_sel;

  // zero wait states: read data is captured in the setup phase
  assign pready = 1'b1;

  // ***************************************************************
  // global operation
  // ***************************************************************
  always_comb begin
    next_global_operation = global_operation;
    if (gc_write) begin
      next_global_operation = set_clear(global_operation,
                                        wdata[GC_WR_SET_GLOBAL_OP],
                                        wdata[GC_WR_CLR_GLOBAL_OP]);  // [RULE4] [RULE17]
      // a clear outside init mode needs the armed shutdown flag
      if (!next_global_operation && !init_mode && !forced_shutdown_enable) begin
        next_global_operation = global_operation;  // [RULE6]
      end
    end
  end

  assign global_op_rise = !global_operation && next_global_operation;
  assign global_op_fall = global_operation && !next_global_operation;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_operation <= GLOBAL_CONTROL_RESET[GC_RD_GLOBAL_OP];
    end else begin
      global_operation <= next_global_operation;
    end
  end

  assign module_enable = global_operation;  // [RULE5]

  // ***************************************************************
  // forced shutdown handshake
  // ***************************************************************
  // any access other than the arming write itself disarms the flag,
  // buffer traffic included, so a late clear can never slip through
  assign other_access = access_done || buffer_req.valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_shutdown_enable <= GLOBAL_CONTROL_RESET[GC_RD_FORCED_SHUTDOWN];
    end else if (gc_write && wdata[GC_WR_SET_SHUTDOWN]) begin
      forced_shutdown_enable <= 1'b1;  // [RULE8]
    end else if (other_access) begin
      forced_shutdown_enable <= 1'b0;  // [RULE7]
    end
  end

  // ***************************************************************
  // buffer access gate
  // ***************************************************************
  // software writes reach this flop only through global operation changes, sleep/stop events directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_access_enabled <= GLOBAL_CONTROL_RESET[GC_RD_BUFFER_ACCESS];
    end else if (sleep_stop_entry || global_op_fall) begin
      buffer_access_enabled <= 1'b0;  // [RULE1] [RULE2]
    end else if (sleep_stop_release || global_op_rise) begin
      buffer_access_enabled <= 1'b1;  // [RULE2]
    end
  end

  assign buffer_grant = buffer_req.valid && buffer_access_enabled;  // [RULE3]

  // ***************************************************************
  // module clock selection
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_clock_select <= CLOCK_SELECT_RESET;  // [RULE10]
    end else if (cs_write) begin
      module_clock_select <= {4'h0, wdata[CS_SEL_WIDTH-1:0]};
    end
  end

  clock_prescaler #(
    .SEL_WIDTH         (CS_SEL_WIDTH)
  ) u_prescaler (
    .pclk              (pclk),
    .presetn           (presetn),
    .divider_sel       (module_clock_select[CS_SEL_WIDTH-1:0]),
    .module_clock_tick (module_clock_tick)
  );

  // ***************************************************************
  // automatic block transmission
  // ***************************************************************
  logic bt_start;
  logic bt_stop;
  logic bt_clear;

  assign bt_start = bt_write && wdata[BT_WR_SET_RUN] && !wdata[BT_WR_CLR_RUN];  // [RULE11] [RULE17]
  assign bt_stop  = bt_write && wdata[BT_WR_CLR_RUN] && !wdata[BT_WR_SET_RUN];  // [RULE11] [RULE17]
  assign bt_clear = bt_write && wdata[BT_WR_SET_CLEAR];                          // [RULE12]

  block_tx_engine #(
    .CLEAR_CYCLES (CLEAR_CYCLES),
    .BUFFERS      (BLOCK_TX_BUFFERS)
  ) u_engine (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (bt_start),
    .stop         (bt_stop),
    .clear_req    (bt_clear),
    .tx_done      (block_tx_done),
    .status       (block_tx_status)
  );

  // ***************************************************************
  // read data and error
  // ***************************************************************
  function automatic logic [REG_WIDTH-1:0] read_mux(input logic [ADDR_WIDTH-1:0] addr);
    logic [REG_WIDTH-1:0] value;
    value = '0;
    if (addr == GLOBAL_CONTROL_ADDR) begin
      value[GC_RD_BUFFER_ACCESS]   = buffer_access_enabled;
      value[GC_RD_FORCED_SHUTDOWN] = forced_shutdown_enable;
      value[GC_RD_GLOBAL_OP]       = global_operation;
    end else if (addr == BLOCK_TX_ADDR) begin
      value[BT_RD_ENGINE_CLEAR]    = block_tx_status.clearing;
      value[BT_RD_RUN]             = block_tx_status.running;
    end else if (addr == CLOCK_SELECT_ADDR) begin
      value[7:0]                   = module_clock_select;
    end
    return value;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= {16'h0000, (pwrite ? 16'h0000 : read_mux(paddr))};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !hit_any;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence engine_clearing_run;
    block_tx_status.clearing [*4];
  endsequence

  sequence engine_back_idle;
    !block_tx_status.clearing && block_tx_status.buffer == 3'h0;
  endsequence

  access_read_only_a: assert property (  // [RULE1]
    gc_write && wdata[GC_RD_BUFFER_ACCESS] && !buffer_access_enabled
      && !global_op_rise && !sleep_stop_release |=> !buffer_access_enabled)
    else $error("buffer access flag rose on a software write");

  access_on_clear_a: assert property (  // [RULE2]
    global_op_fall |=> !buffer_access_enabled && !global_operation)
    else $error("buffer access flag stayed set after global clear");

  access_on_set_a: assert property (  // [RULE2]
    global_op_rise && !sleep_stop_entry |=> buffer_access_enabled)
    else $error("buffer access flag not set with global operation");

  access_sleep_a: assert property (  // [RULE2]
    sleep_stop_entry |=> !buffer_access_enabled)
    else $error("buffer access flag stayed set on sleep entry");

  access_wake_a: assert property (  // [RULE2]
    sleep_stop_release && !sleep_stop_entry && !global_op_fall |=> buffer_access_enabled)
    else $error("buffer access flag not set on sleep release");

  buffer_block_a: assert property (  // [RULE3]
    !buffer_access_enabled |-> !buffer_grant)
    else $error("buffer access granted while blocked");

  global_set_a: assert property (  // [RULE4]
    gc_write && wdata[GC_WR_SET_GLOBAL_OP] && !wdata[GC_WR_CLR_GLOBAL_OP] |=> global_operation)
    else $error("global operation not set by set pattern");

  global_hold_a: assert property (  // [RULE4] [RULE17]
    gc_write && (wdata[GC_WR_SET_GLOBAL_OP] == wdata[GC_WR_CLR_GLOBAL_OP])
      |=> global_operation == $past(global_operation))
    else $error("global operation changed on a no-change pattern");

  global_clear_a: assert property (  // [RULE6]
    gc_write && wdata[GC_WR_CLR_GLOBAL_OP] && !wdata[GC_WR_SET_GLOBAL_OP]
      && (init_mode || forced_shutdown_enable) |=> !global_operation)
    else $error("global operation not cleared by permitted clear");

  module_enable_a: assert property (  // [RULE5]
    module_enable == global_operation)
    else $error("module enable differs from global operation");

  global_clear_guard_a: assert property (  // [RULE6]
    $fell(global_operation) |-> $past(init_mode) || $past(forced_shutdown_enable))
    else $error("global operation cleared without permission");

  shutdown_drop_a: assert property (  // [RULE7]
    forced_shutdown_enable && other_access && !(gc_write && wdata[GC_WR_SET_SHUTDOWN])
      |=> !forced_shutdown_enable)
    else $error("shutdown enable survived another access");

  shutdown_set_a: assert property (  // [RULE8]
    gc_write && wdata[GC_WR_SET_SHUTDOWN] |=> forced_shutdown_enable)
    else $error("shutdown enable not set by bit nine");

  prescale_gap_a: assert property (  // [RULE10]
    module_clock_tick && module_clock_select == CLOCK_SELECT_RESET && !cs_write
      |=> !module_clock_tick)
    else $error("divide by sixteen ticked twice in a row");

  run_start_a: assert property (  // [RULE11]
    bt_start && !bt_clear && !block_tx_status.clearing |=> block_tx_status.running)
    else $error("block transmission did not start");

  run_stop_a: assert property (  // [RULE11]
    bt_stop && !bt_clear |=> !block_tx_status.running)
    else $error("block transmission did not stop");

  clear_status_a: assert property (  // [RULE12]
    bt_clear && !block_tx_status.clearing |=> engine_clearing_run ##1 engine_back_idle)
    else $error("engine clear status not self-clearing in time");

  restart_zero_a: assert property (  // [RULE13]
    $fell(block_tx_status.clearing) |-> block_tx_status.buffer == 3'h0)
    else $error("engine did not rewind to buffer zero");

endmodule // can_global_control

// ===== hdl/can_global_pkg.sv
package can_global_pkg;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int          ADDR_WIDTH            = 18;
  localparam int          DATA_WIDTH            = 32;
  localparam int          REG_WIDTH             = 16;

  // printed offsets are register indices; byte address is index * 4
  localparam logic [15:0] GLOBAL_CONTROL_INDEX  = 16'hFF64;
  localparam logic [15:0] BLOCK_TX_INDEX        = 16'hFF66;
  localparam logic [15:0] CLOCK_SELECT_INDEX    = 16'hFF6E;
  localparam logic [ADDR_WIDTH-1:0] GLOBAL_CONTROL_ADDR = {GLOBAL_CONTROL_INDEX, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] BLOCK_TX_ADDR       = {BLOCK_TX_INDEX, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] CLOCK_SELECT_ADDR   = {CLOCK_SELECT_INDEX, 2'b00};

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          GC_RD_BUFFER_ACCESS   = 15;
  localparam int          GC_RD_FORCED_SHUTDOWN = 1;
  localparam int          GC_RD_GLOBAL_OP       = 0;
  localparam int          GC_WR_SET_SHUTDOWN    = 9;
  localparam int          GC_WR_SET_GLOBAL_OP   = 8;
  localparam int          GC_WR_CLR_GLOBAL_OP   = 0;
  localparam int          BT_RD_ENGINE_CLEAR    = 1;
  localparam int          BT_RD_RUN             = 0;
  localparam int          BT_WR_SET_CLEAR       = 9;
  localparam int          BT_WR_SET_RUN         = 8;
  localparam int          BT_WR_CLR_RUN         = 0;
  localparam int          CS_SEL_WIDTH          = 4;

  // ***************************************************************
  // reset values and timing counts
  // ***************************************************************
  localparam logic [15:0] GLOBAL_CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] BLOCK_TX_RESET        = 16'h0000;
  localparam logic [7:0]  CLOCK_SELECT_RESET    = 8'h0F;
  localparam int          ENGINE_CLEAR_CYCLES   = 4;
  localparam int          BLOCK_TX_BUFFERS      = 8;
  localparam int          BLOCK_TX_PTR_WIDTH    = 3;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic valid;
    logic write;
  } buffer_req_type;

  typedef struct packed {
    logic                          running;
    logic                          clearing;
    logic [BLOCK_TX_PTR_WIDTH-1:0] buffer;
  } block_tx_status_type;

  // paired set/clear decoding used for the global operation bit
  function automatic logic set_clear(input logic current,
                                     input logic set_bit,
                                     input logic clear_bit);
    if (set_bit && !clear_bit) begin
      return 1'b1;
    end else if (clear_bit && !set_bit) begin
      return 1'b0;
    end
    return current;
  endfunction

endpackage

// ===== hdl/clock_prescaler.sv
`timescale 1ns/10ps
module clock_prescaler
  import can_global_pkg::*;
#(
  parameter int SEL_WIDTH = CS_SEL_WIDTH
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [SEL_WIDTH-1:0] divider_sel,
  output logic                      module_clock_tick
);

  logic [SEL_WIDTH-1:0] count;

  // greater-or-equal so a smaller divisor written mid-count takes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (count >= divider_sel) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // one tick every divider_sel + 1 cycles
  assign module_clock_tick = (count >= divider_sel);  // [RULE10]

endmodule // clock_prescaler

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import can_global_pkg::*;
  localparam int CLR = 4;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                  init_mode, sleep_entry, sleep_release, tx_done;
  logic                  buffer_grant, module_enable, tick, rerr;
  logic [ADDR_WIDTH-1:0] paddr;
  logic [DATA_WIDTH-1:0] pwdata, prdata, rdata;
  buffer_req_type        buffer_req;
  block_tx_status_type   st;
  int                    err_total, total_checks, seed, n, i;
  int                    m_global, m_shutdown, m_access, m_run, m_buf, m_sel;

  can_global_control #(.CLEAR_CYCLES(CLR)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .init_mode(init_mode), .sleep_stop_entry(sleep_entry),
    .sleep_stop_release(sleep_release), .buffer_req(buffer_req),
    .buffer_grant(buffer_grant), .block_tx_done(tx_done), .block_tx_status(st),
    .module_enable(module_enable), .module_clock_tick(tick));

  always #2 pclk = ~pclk;

  // ***************************************************************
  // checking and bus tasks
  // ***************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    rerr  = pslverr;
    chk("ready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_gc();
    return {16'h0, m_access[0], 13'h0, m_shutdown[0], m_global[0]};
  endfunction

  // the model follows each write; shutdown arming lasts one access only
  task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [15:0] d);
    int armed;
    armed = m_shutdown;
    apb(1'b1, a, {16'h0, d});
    m_shutdown = 0;
    if (a == GLOBAL_CONTROL_ADDR) begin
      if (d[8] && !d[0]) begin
        if (m_global == 0) m_access = 1;
        m_global = 1;
      end else if (d[0] && !d[8] && (init_mode || armed != 0)) begin
        if (m_global != 0) m_access = 0;
        m_global = 0;
      end
      m_shutdown = d[9];
    end else if (a == BLOCK_TX_ADDR) begin
      if (d[9]) begin
        m_run = 0;
        m_buf = 0;
      end else if (d[8] && !d[0]) m_run = 1;
      else if (d[0] && !d[8]) m_run = 0;
    end else if (a == CLOCK_SELECT_ADDR) m_sel = d[3:0];
    chk("write error", 32'h0, {31'h0, rerr});
  endtask

  task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    m_shutdown = 0;
    chk(name, exp, rdata);
    chk("read error", 32'h0, {31'h0, rerr});
  endtask

  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) sleep_entry <= 1'b1;
    else if (which == 1) sleep_release <= 1'b1;
    else tx_done <= 1'b1;
    @(posedge pclk);
    sleep_entry   <= 1'b0;
    sleep_release <= 1'b0;
    tx_done       <= 1'b0;
    @(negedge pclk);
  endtask

  // skips two periods so a shortened first period after a write is ignored
  task automatic tick_period(output int p);
    int k;
    for (k = 0; k < 2; k++) begin
      p = 0;
      do begin
        @(negedge pclk);
        p++;
      end while (tick !== 1'b1 && p < 40);
    end
    p = 0;
    do begin
      @(negedge pclk);
      p++;
    end while (tick !== 1'b1 && p < 40);
  endtask

  function automatic logic [31:0] stat();
    return {28'h0, st.running, st.buffer};
  endfunction

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; init_mode = 1'b0; sleep_entry = 1'b0; sleep_release = 1'b0;
    tx_done = 1'b0; buffer_req = '0; seed = 75130; err_total = 0; total_checks = 0;
    m_global = 0; m_shutdown = 0; m_access = 0; m_run = 0; m_buf = 0; m_sel = 15;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(GLOBAL_CONTROL_ADDR, 32'h0, "global reset");
    rd(BLOCK_TX_ADDR, 32'h0, "block tx reset");
    rd(CLOCK_SELECT_ADDR, 32'h0F, "clock sel reset");
    apb(1'b0, 18'h00010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdata);
    $display("test reset done");
    wr(GLOBAL_CONTROL_ADDR, 16'h8000);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "access flag read only");
    buffer_req <= '{valid: 1'b1, write: 1'b1};
    @(negedge pclk);
    chk("grant blocked", 32'h0, {31'h0, buffer_grant});
    @(posedge pclk);
    buffer_req <= '0;
    wr(GLOBAL_CONTROL_ADDR, 16'h0101);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "both bits no change");
    wr(GLOBAL_CONTROL_ADDR, 16'h0100);
    @(negedge pclk);
    chk("module enable", 32'h1, {31'h0, module_enable});
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "global set");
    buffer_req <= '{valid: 1'b1, write: 1'b0};
    @(negedge pclk);
    chk("grant open", 32'h1, {31'h0, buffer_grant});
    @(posedge pclk);
    buffer_req <= '0;
    wr(GLOBAL_CONTROL_ADDR, 16'h0001);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "clear refused");
    $display("test global op done");
    wr(GLOBAL_CONTROL_ADDR, 16'h0200);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "shutdown armed");
    wr(GLOBAL_CONTROL_ADDR, 16'h0001);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "read cancels");
    wr(GLOBAL_CONTROL_ADDR, 16'h0200);
    rd(CLOCK_SELECT_ADDR, {24'h0, 4'h0, m_sel[3:0]}, "other access");
    wr(GLOBAL_CONTROL_ADDR, 16'h0001);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "other cancels");
    wr(GLOBAL_CONTROL_ADDR, 16'h0200);
    wr(GLOBAL_CONTROL_ADDR, 16'h0001);
    @(negedge pclk);
    chk("shutdown done", 32'h0, {31'h0, module_enable});
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "shutdown read");
    $display("test shutdown done");
    wr(GLOBAL_CONTROL_ADDR, 16'h0100);
    init_mode <= 1'b1;
    wr(GLOBAL_CONTROL_ADDR, 16'h0001);
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "init clear");
    init_mode <= 1'b0;
    wr(GLOBAL_CONTROL_ADDR, 16'h0100);
    pulse(0);
    m_access = 0;
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "sleep entry");
    pulse(1);
    m_access = 1;
    rd(GLOBAL_CONTROL_ADDR, exp_gc(), "sleep release");
    $display("test access flag done");
    for (i = 0; i < 8; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 15 : $random(seed);
      wr(CLOCK_SELECT_ADDR, n[15:0]);
      rd(CLOCK_SELECT_ADDR, {28'h0, m_sel[3:0]}, "clock sel");
      tick_period(n);
      chk("tick period", m_sel + 1, n);
    end
    $display("test prescaler done");
    wr(BLOCK_TX_ADDR, 16'h0100);
    @(negedge pclk);
    chk("run started", {28'h0, m_run[0], m_buf[2:0]}, stat());
    for (i = 0; i < 3; i++) begin
      pulse(2);
      m_buf++;
      chk("buffer advance", {28'h0, m_run[0], m_buf[2:0]}, stat());
    end
    wr(BLOCK_TX_ADDR, 16'h0101);
    rd(BLOCK_TX_ADDR, m_run, "run no change");
    wr(BLOCK_TX_ADDR, 16'h0001);
    rd(BLOCK_TX_ADDR, m_run, "run stopped");
    wr(BLOCK_TX_ADDR, 16'h0200);
    n = 0;
    @(negedge pclk);
    while (st.clearing === 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    chk("clear length", CLR, n);
    rd(BLOCK_TX_ADDR, m_run, "clear self ends");
    wr(BLOCK_TX_ADDR, 16'h0100);
    @(negedge pclk);
    chk("restart buffer", {28'h0, m_run[0], m_buf[2:0]}, stat());
    wr(BLOCK_TX_ADDR, 16'h0001);
    rd(BLOCK_TX_ADDR, m_run, "default restored");
    $display("test block tx done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
endmodule // testbench
